// ---- design/gpio3_consts.vh ----
/*
 * constants for the three-port parallel i/o block: control field positions,
 * edge encodings and handshake states.
 * assumes: included by bare name from the design files under design/.
 */
`ifndef GPIO3_CONSTS_VH
`define GPIO3_CONSTS_VH

// ==========================================
// control register field positions
`define POWER_CONTROL_REG_COMP_OUT_BIT 0
`define P3MODE_ANALOG_BIT 1
`define IRQ_EDGE_LSB 6
`define IRQ_EDGE_MSB 7

// ==========================================
// edge select encodings (interrupt request register bits 7..6)
`define EDGE_FALL 2'h0
`define EDGE_RISE 2'h1
`define EDGE_BOTH 2'h2

// ==========================================
// reset values
`define PORT_OUT_RST 8'h00
`define P3_OUT_RST 4'h0

// ==========================================
// buffer shape
`define FIFO_WIDTH 8
`define FIFO_DEPTH 16
`define FIFO_AW 4

// ==========================================
// handshake states, one-hot
`define HS_IDLE 4'h1
`define HS_SETUP 4'h2
`define HS_HOLD 4'h4
`define HS_RELEASE 4'h8

`endif

// ---- design/byte_fifo.v ----
/*
 * synchronous fifo with valid/ready on both sides, registered flags.
 * assumes: one clock, synchronous active-low reset.
 */
`include "gpio3_consts.vh"

module byte_fifo #(
   parameter WIDTH = `FIFO_WIDTH,
   parameter DEPTH = `FIFO_DEPTH,
   parameter AW = `FIFO_AW
) (
   // clock and reset
   input wire i_clk,
   input wire i_rst_n,
   // fill side
   input wire i_in_valid,
   input wire [WIDTH-1:0] i_in_data,
   output reg o_in_ready,
   // drain side
   output reg o_out_valid,
   output wire [WIDTH-1:0] o_out_data,
   input wire i_out_ready
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire push;
   wire pop;
   wire [AW:0] next_count;

   assign push = i_in_valid & o_in_ready;
   assign pop = i_out_ready & o_out_valid;
   assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   assign o_out_data = mem[rd_ptr];

   // ==========================================
   // storage has no reset; flags guard every read
   always @(posedge i_clk) begin
      if (push) begin
         mem[wr_ptr] <= i_in_data;
      end
   end

   // ==========================================
   // pointers and flags
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
         o_in_ready <= 1'b1;
         o_out_valid <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         count <= next_count;
         o_in_ready <= (next_count != DEPTH[AW:0]);
         o_out_valid <= (next_count != {(AW+1){1'b0}});
      end
   end

endmodule

// ---- design/three_port_io.v ----
/*
 * three-port parallel i/o: nibble-configured port 0, bit-configured port 2,
 * fixed-direction port 3 with handshake, comparator, interrupt-edge and
 * timer 1 pin functions. a 16-word fifo buffers port 0 handshake data.
 * assumes: control bits come from registers elsewhere on the same clock;
 * comparator results arrive as digital levels from the analog front end.
 */
// Functional notes
// - port 0 has eight lines whose direction is set per nibble, 3..0 and 7..4.
// - one setting makes every port 0 output nibble push-pull or open-drain.
// - port 0 handshake uses third-port line 2 in and line 5 out.
// - port 0 handshake direction follows the direction of its upper nibble.
// - port 2 has eight lines, each set as input or output on its own.
// - one setting makes all port 2 output bits push-pull or open-drain.
// - port 2 handshake uses third-port lines 1 in and 6 out, direction from bit 7.
// - port 3 has fixed inputs on lines 3..0 and fixed push-pull outputs on 7..4.
// - comparator results of lines 1 and 2 go out on lines 4 and 7 when power control bit 0 is 1.
// - port 3 mode bit 1 enables analog mode, with line 3 as shared reference.
// - lines 0 and 3 raise interrupt requests on falling edges only.
// - lines 1 and 2 raise requests on falling, rising or both edges per request register bits 7..6.
// - timer 1 takes its external input from line 1 and drives line 6.
// - one setting each for ports 0 and 2 switches that port's output buffers to reduced-emission drive.
// - outside analog mode line 3 is a plain register input and interrupt source.
`include "gpio3_consts.vh"

module three_port_io (
   // clock and reset
   input wire i_clk,
   input wire i_rst_n,
   // configuration
   input wire i_p0_lo_out,
   input wire i_p0_hi_out,
   input wire i_p0_open_drain,
   input wire i_p0_low_emi,
   input wire i_p0_hs_en,
   input wire [7:0] i_p2_dir_out,
   input wire i_p2_open_drain,
   input wire i_p2_low_emi,
   input wire i_p2_hs_en,
   input wire [7:0] i_power_control_reg,
   input wire [7:0] i_third_port_mode_reg,
   input wire [7:0] i_irq_request_reg,
   input wire i_timer1_out_en,
   // software data access
   input wire i_p0_wr,
   input wire [7:0] i_p0_wr_data,
   output wire o_p0_tx_ready,
   output wire o_p0_rx_valid,
   output wire [7:0] o_p0_rx_data,
   input wire i_p0_rx_ready,
   input wire i_p2_wr,
   input wire [7:0] i_p2_wr_data,
   output reg o_p2_tx_busy,
   output reg o_p2_rx_valid,
   output reg [7:0] o_p2_rx_data,
   input wire i_p2_rx_ack,
   input wire [3:0] i_p3_out_data,
   output reg [7:0] o_p0_rd_data,
   output reg [7:0] o_p2_rd_data,
   output reg [3:0] o_p3_rd_data,
   // interrupt requests and timer 1
   output reg [3:0] o_irq_req,
   output reg o_timer1_ext_input,
   input wire i_timer1_output,
   // port 0 and port 2 pins
   input wire [7:0] i_p0_pin,
   output reg [7:0] o_p0_pin,
   output reg [7:0] o_p0_oe,
   output reg o_p0_slow,
   input wire [7:0] i_p2_pin,
   output reg [7:0] o_p2_pin,
   output reg [7:0] o_p2_oe,
   output reg o_p2_slow,
   // port 3 pins
   input wire i_p3_line0_in,
   input wire i_p3_line1_in,
   input wire i_p3_line2_in,
   input wire i_p3_line3_ref_in,
   input wire i_cmp1_result,
   input wire i_cmp2_result,
   output reg o_p3_line4_out,
   output reg o_p3_line5_out,
   output reg o_p3_line6_out,
   output reg o_p3_line7_out
);

   // ==========================================
   // helpers
   // drive for one port: {pin value, enable}; open-drain only pulls low
   function [15:0] pin_drive;
      input [7:0] val;
      input [7:0] dir_out;
      input od;
      begin
         if (od) begin
            pin_drive = {8'h00, dir_out & ~val};
         end else begin
            pin_drive = {val & dir_out, dir_out};
         end
      end
   endfunction

   // ==========================================
   // input synchronisers: every pin passes two flops
   reg [23:0] sync1;
   reg [23:0] sync2;
   reg [5:0] prev;
   wire [23:0] raw_in;
   wire [7:0] p0_in;
   wire [7:0] p2_in;
   wire [3:0] p3_in;
   wire [1:0] cmp_in;

   assign raw_in = {i_cmp2_result, i_cmp1_result, i_p3_line3_ref_in, i_p3_line2_in,
                    i_p3_line1_in, i_p3_line0_in, i_p2_pin, i_p0_pin};
   assign p0_in = sync2[7:0];
   assign p2_in = sync2[15:8];
   assign p3_in = sync2[19:16];
   assign cmp_in = sync2[21:20];

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         sync1 <= 24'h000000;
         sync2 <= 24'h000000;
      end else begin
         sync1 <= raw_in;
         sync2 <= sync1;
      end
   end

   // ==========================================
   // mode decode
   wire analog;
   wire comp_out;
   wire [1:0] edge_sel;
   wire [7:0] p0_dir;
   wire [1:0] hs_en;
   wire [1:0] hs_send;
   wire [1:0] peer;

   assign analog = i_third_port_mode_reg[`P3MODE_ANALOG_BIT];
   assign comp_out = i_power_control_reg[`POWER_CONTROL_REG_COMP_OUT_BIT];
   assign edge_sel = i_irq_request_reg[`IRQ_EDGE_MSB:`IRQ_EDGE_LSB];
   assign p0_dir = {{4{i_p0_hi_out}}, {4{i_p0_lo_out}}};
   assign hs_en = {i_p2_hs_en, i_p0_hs_en};
   // lower nibble is trusted to match the upper one in handshake mode
   assign hs_send = {i_p2_dir_out[7], i_p0_hi_out};
   assign peer = {p3_in[1], p3_in[2]};

   // ==========================================
   // handshake engines, one each for ports 0 and 2
   reg [7:0] hs_state;
   reg [1:0] hs_line;
   reg [15:0] hs_data;
   reg [7:0] p0_out;
   reg [7:0] p2_out;
   wire [1:0] src_valid;
   wire [15:0] src_data;
   wire [1:0] room;
   wire [1:0] hs_pop;
   wire [1:0] hs_push;

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : hs
         wire [3:0] st;
         assign st = hs_state[4*g+3:4*g];
         // a word leaves only once the peer is ready
         assign hs_pop[g] = hs_en[g] & hs_send[g] & st[0] & src_valid[g] & peer[g];
         assign hs_push[g] = hs_en[g] & ~hs_send[g] & st[0] & room[g] & peer[g];
         always @(posedge i_clk) begin
            if (!i_rst_n) begin
               hs_state[4*g+3:4*g] <= `HS_IDLE;
               hs_line[g] <= 1'b0;
               hs_data[8*g+7:8*g] <= `PORT_OUT_RST;
            end else if (!hs_en[g]) begin
               hs_state[4*g+3:4*g] <= `HS_IDLE;
               hs_line[g] <= 1'b0;
            end else if (hs_send[g]) begin
               case (st)
                  `HS_IDLE: begin
                     hs_line[g] <= 1'b0;
                     if (hs_pop[g]) begin
                        hs_data[8*g+7:8*g] <= src_data[8*g+7:8*g];
                        hs_state[4*g+3:4*g] <= `HS_SETUP;
                     end
                  end
                  `HS_SETUP: begin
                     // data reaches the pins at this edge, one cycle before line 5 rises
                     hs_line[g] <= 1'b1;
                     hs_state[4*g+3:4*g] <= `HS_HOLD;
                  end
                  `HS_HOLD: begin
                     if (!peer[g]) begin
                        hs_line[g] <= 1'b0;
                        hs_state[4*g+3:4*g] <= `HS_RELEASE;
                     end
                  end
                  `HS_RELEASE: begin
                     if (peer[g]) begin
                        hs_state[4*g+3:4*g] <= `HS_IDLE;
                     end
                  end
                  default: begin
                     hs_state[4*g+3:4*g] <= `HS_IDLE;
                     hs_line[g] <= 1'b0;
                  end
               endcase
            end else begin
               case (st)
                  `HS_IDLE: begin
                     if (hs_push[g]) begin
                        hs_line[g] <= 1'b0;
                        hs_state[4*g+3:4*g] <= `HS_HOLD;
                     end else begin
                        hs_line[g] <= room[g];
                     end
                  end
                  `HS_HOLD: begin
                     hs_line[g] <= 1'b0;
                     if (!peer[g]) begin
                        hs_state[4*g+3:4*g] <= `HS_IDLE;
                     end
                  end
                  default: begin
                     hs_state[4*g+3:4*g] <= `HS_IDLE;
                     hs_line[g] <= 1'b0;
                  end
               endcase
            end
         end
      end
   endgenerate

   // ==========================================
   // port 0 buffer: direction decides which side fills it
   wire p0_hs_tx;
   wire p0_hs_rx;
   wire fifo_in_valid;
   wire [7:0] fifo_in_data;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [7:0] fifo_out_data;
   wire fifo_out_ready;

   assign p0_hs_tx = i_p0_hs_en & i_p0_hi_out;
   assign p0_hs_rx = i_p0_hs_en & ~i_p0_hi_out;
   assign fifo_in_valid = p0_hs_tx ? i_p0_wr : hs_push[0];
   assign fifo_in_data = p0_hs_tx ? i_p0_wr_data : p0_in;
   assign fifo_out_ready = p0_hs_tx ? hs_pop[0] : i_p0_rx_ready;
   assign o_p0_tx_ready = p0_hs_tx & fifo_in_ready;
   assign o_p0_rx_valid = ~p0_hs_tx & fifo_out_valid;
   assign o_p0_rx_data = fifo_out_data;
   assign src_valid = {o_p2_tx_busy, p0_hs_tx & fifo_out_valid};
   assign src_data = {p2_out, fifo_out_data};
   // full fifo holds ready low at the peer
   assign room = {~o_p2_rx_valid, p0_hs_rx & fifo_in_ready};

   byte_fifo #(
      .WIDTH(`FIFO_WIDTH),
      .DEPTH(`FIFO_DEPTH),
      .AW(`FIFO_AW)
   ) u_p0_fifo (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_in_valid(fifo_in_valid),
      .i_in_data(fifo_in_data),
      .o_in_ready(fifo_in_ready),
      .o_out_valid(fifo_out_valid),
      .o_out_data(fifo_out_data),
      .i_out_ready(fifo_out_ready)
   );

   // ==========================================
   // output registers and port 2 single-word path
   wire [7:0] p0_val;
   wire [7:0] p2_val;
   wire [15:0] p0_drv;
   wire [15:0] p2_drv;

   assign p0_val = p0_hs_tx ? hs_data[7:0] : p0_out;
   assign p2_val = (i_p2_hs_en & i_p2_dir_out[7]) ? hs_data[15:8] : p2_out;
   assign p0_drv = pin_drive(p0_val, p0_dir, i_p0_open_drain);
   assign p2_drv = pin_drive(p2_val, i_p2_dir_out, i_p2_open_drain);

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         p0_out <= `PORT_OUT_RST;
         p2_out <= `PORT_OUT_RST;
         o_p2_tx_busy <= 1'b0;
         o_p2_rx_valid <= 1'b0;
         o_p2_rx_data <= `PORT_OUT_RST;
      end else begin
         if (i_p0_wr && !p0_hs_tx) begin
            p0_out <= i_p0_wr_data;
         end
         if (i_p2_wr) begin
            p2_out <= i_p2_wr_data;
         end
         // a new write in the pop cycle keeps the word pending
         if (i_p2_wr && i_p2_hs_en && i_p2_dir_out[7]) begin
            o_p2_tx_busy <= 1'b1;
         end else if (hs_pop[1] || !i_p2_hs_en) begin
            o_p2_tx_busy <= 1'b0;
         end
         if (hs_push[1]) begin
            o_p2_rx_valid <= 1'b1;
            o_p2_rx_data <= p2_in;
         end else if (i_p2_rx_ack) begin
            o_p2_rx_valid <= 1'b0;
         end
      end
   end

   // ==========================================
   // pins, read-back, port 3 outputs, interrupt edges
   wire [3:0] p3_eff;
   wire [1:0] rise;
   wire [1:0] fall;
   wire [3:0] next_irq;

   // in analog mode lines 1/2 read as comparator results, line 3 is the reference
   assign p3_eff = analog ? {1'b0, cmp_in, p3_in[0]} : p3_in;
   assign rise = p3_eff[2:1] & ~prev[2:1];
   assign fall = ~p3_eff[2:1] & prev[2:1];
   assign next_irq[0] = ~p3_eff[0] & prev[0];
   assign next_irq[3] = ~analog & ~p3_eff[3] & prev[3];
   assign next_irq[2:1] = (edge_sel == `EDGE_FALL) ? fall :
                          (edge_sel == `EDGE_RISE) ? rise : (rise | fall);

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         prev <= 6'h00;
         o_irq_req <= 4'h0;
         o_p0_pin <= 8'h00;
         o_p0_oe <= 8'h00;
         o_p2_pin <= 8'h00;
         o_p2_oe <= 8'h00;
         o_p0_slow <= 1'b0;
         o_p2_slow <= 1'b0;
         o_p0_rd_data <= 8'h00;
         o_p2_rd_data <= 8'h00;
         o_p3_rd_data <= 4'h0;
         o_timer1_ext_input <= 1'b0;
         o_p3_line4_out <= 1'b0;
         o_p3_line5_out <= 1'b0;
         o_p3_line6_out <= 1'b0;
         o_p3_line7_out <= 1'b0;
      end else begin
         prev <= {2'h0, p3_eff};
         o_irq_req <= next_irq;
         o_p0_pin <= p0_drv[15:8];
         o_p0_oe <= p0_drv[7:0];
         o_p2_pin <= p2_drv[15:8];
         o_p2_oe <= p2_drv[7:0];
         o_p0_slow <= i_p0_low_emi;
         o_p2_slow <= i_p2_low_emi;
         o_p0_rd_data <= (p0_dir & p0_out) | (~p0_dir & p0_in);
         o_p2_rd_data <= (i_p2_dir_out & p2_out) | (~i_p2_dir_out & p2_in);
         o_p3_rd_data <= p3_eff;
         o_timer1_ext_input <= p3_in[1];
         // fixed push-pull outputs: no enable, always driven
         o_p3_line4_out <= comp_out ? cmp_in[0] : i_p3_out_data[0];
         o_p3_line7_out <= comp_out ? cmp_in[1] : i_p3_out_data[3];
         o_p3_line5_out <= i_p0_hs_en ? hs_line[0] : i_p3_out_data[1];
         if (i_p2_hs_en) begin
            o_p3_line6_out <= hs_line[1];
         end else if (i_timer1_out_en) begin
            o_p3_line6_out <= i_timer1_output;
         end else begin
            o_p3_line6_out <= i_p3_out_data[2];
         end
      end
   end

endmodule

// ---- tb/gpio3_assertions.sv ----
/* checker for three_port_io: pin drive, port 3 routing, edge requests.
   assumes: bound to three_port_io, inputs change between clock edges. */
// ====================
// checker
module gpio3_checker (
   input wire i_clk, i_rst_n, i_p0_lo_out, i_p0_hi_out, i_p0_open_drain, i_p0_low_emi, i_p0_hs_en,
   input wire i_p2_open_drain, i_p2_low_emi, i_p2_hs_en, i_timer1_out_en, i_timer1_output,
   input wire i_p3_line0_in, i_p3_line1_in, i_cmp1_result, o_p0_slow, o_p2_slow, o_timer1_ext_input,
   input wire o_p3_line4_out, o_p3_line5_out, o_p3_line6_out,
   input wire [7:0] i_p2_dir_out, i_power_control_reg, i_third_port_mode_reg, i_irq_request_reg,
   input wire [7:0] o_p0_oe, o_p0_pin, o_p2_oe, o_p2_pin,
   input wire [3:0] i_p3_out_data, o_irq_req
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   wire [7:0] dir0 = {{4{i_p0_hi_out}}, {4{i_p0_lo_out}}};
   wire ana = i_third_port_mode_reg[1];
   wire [1:0] sel = i_irq_request_reg[7:6];
   property p_p0_pp; !i_p0_open_drain && !i_p0_hs_en |=> o_p0_oe == $past(dir0); endproperty
   a_p0_pp: assert property (p_p0_pp) else $error("port 0 enables wrong");
   property p_p0_od; i_p0_open_drain && !i_p0_hs_en |=> o_p0_pin == 8'h00 && (o_p0_oe & ~$past(dir0)) == 8'h00;
   endproperty
   a_p0_od: assert property (p_p0_od) else $error("port 0 open drain wrong");
   property p_p2_pp; !i_p2_open_drain && !i_p2_hs_en |=> o_p2_oe == $past(i_p2_dir_out) && (o_p2_pin & ~o_p2_oe) == 8'h00;
   endproperty
   a_p2_pp: assert property (p_p2_pp) else $error("port 2 push pull wrong");
   property p_p2_od; i_p2_open_drain && !i_p2_hs_en |=> o_p2_pin == 8'h00 && (o_p2_oe & ~$past(i_p2_dir_out)) == 8'h00;
   endproperty
   a_p2_od: assert property (p_p2_od) else $error("port 2 open drain wrong");
   property p_slow; i_rst_n |=> {o_p0_slow, o_p2_slow} == $past({i_p0_low_emi, i_p2_low_emi}); endproperty
   a_slow: assert property (p_slow) else $error("drive strength select wrong");
   property p_sw5; (!i_p0_hs_en) [*2] |=> o_p3_line5_out == $past(i_p3_out_data[1]); endproperty
   a_sw5: assert property (p_sw5) else $error("line 5 software value lost");
   property p_cmp; (i_power_control_reg[0] && ana && i_cmp1_result) [*4] |-> o_p3_line4_out; endproperty
   a_cmp: assert property (p_cmp) else $error("comparator not routed");
   property p_t1o; !i_p2_hs_en && i_timer1_out_en |=> o_p3_line6_out == $past(i_timer1_output); endproperty
   a_t1o: assert property (p_t1o) else $error("timer output not on line 6");
   property p_t1i; i_p3_line1_in [*4] |-> o_timer1_ext_input; endproperty
   a_t1i: assert property (p_t1i) else $error("timer input not from line 1");
   property p_irq0r; $rose(i_p3_line0_in) |-> ##1 (!o_irq_req[0]) [*5]; endproperty
   a_irq0r: assert property (p_irq0r) else $error("line 0 rising edge requested");
   property p_irq0f; $fell(i_p3_line0_in) |-> ##[2:5] o_irq_req[0]; endproperty
   a_irq0f: assert property (p_irq0f) else $error("line 0 falling edge missed");
   property p_irq1n; $rose(i_p3_line1_in) && !ana && sel == 2'h0 |-> ##1 (!o_irq_req[1]) [*5]; endproperty
   a_irq1n: assert property (p_irq1n) else $error("line 1 rise requested in falling mode");
   property p_irq1r; $rose(i_p3_line1_in) && !ana && sel != 2'h0 |-> ##[2:5] o_irq_req[1]; endproperty
   a_irq1r: assert property (p_irq1r) else $error("line 1 rise missed");
   property p_ana3; ana [*6] |-> !o_irq_req[3]; endproperty
   a_ana3: assert property (p_ana3) else $error("reference line requested in analog mode");
endmodule
bind three_port_io gpio3_checker u_chk (.*);

// ---- tb/hs_peer.sv ----
/* port 0 handshake partner: sinks or sources one byte per transfer.
   assumes: the bench resolves the shared data pins and line wiring. */
module hs_peer (
   input wire logic clk, en, src, hold, dev_line,
   input wire logic [7:0] pins, dly,
   output logic peer_line,
   output logic [7:0] peer_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got[$];
   logic [7:0] tx[$];
   task automatic until_line(input logic v);
      for (int n = 0; n < 3000 && dev_line !== v; n++) @(negedge clk);
   endtask
   initial begin
      peer_line = 1'b0;
      peer_data = 8'h00;
      forever begin
         @(negedge clk);
         if (en && !src) begin
            if (!hold && dev_line === 1'b1) begin
               got.push_back(pins);
               peer_line = 1'b0;
               until_line(1'b0);
               repeat (dly) @(negedge clk);
            end else
               peer_line = !hold;
         end else if (en && tx.size() > 0) begin
            until_line(1'b1);
            peer_data = tx.pop_front();
            @(negedge clk);
            peer_line = 1'b1;
            until_line(1'b0);
            peer_line = 1'b0;
            peer_data = ~peer_data;
            repeat (dly) @(negedge clk);
         end else begin
            // released lines never hold a stale byte
            peer_line = 1'b0;
            peer_data = ~peer_data;
         end
      end
   end
endmodule

// ---- tb/tb.sv ----
/* self-checking bench for three_port_io, inputs driven at falling edge.
   assumes: hs_peer stands on port 0 pins and lines 2 and 5. */
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk = 0, i_rst_n = 0, i_p0_lo_out = 0, i_p0_hi_out = 0, i_p0_open_drain = 0, i_p0_low_emi = 0;
   logic i_p0_hs_en = 0, i_p2_open_drain = 0, i_p2_low_emi = 0, i_p2_hs_en = 0, i_timer1_out_en = 0;
   logic i_timer1_output = 0, i_p0_wr = 0, i_p0_rx_ready = 0, i_p2_wr = 0, i_p2_rx_ack = 0;
   logic i_cmp1_result = 0, i_cmp2_result = 0, hold = 1, src = 0;
   logic [7:0] i_p2_dir_out = 0, i_power_control_reg = 0, i_third_port_mode_reg = 0, i_irq_request_reg = 0;
   logic [7:0] i_p0_wr_data = 0, i_p2_wr_data = 0, i_p2_pin = 0, dly = 8'h03;
   logic [3:0] i_p3_out_data = 0, l3 = 0;
   wire o_p0_tx_ready, o_p0_rx_valid, o_p2_tx_busy, o_p2_rx_valid, o_timer1_ext_input, o_p0_slow, o_p2_slow;
   wire o_p3_line4_out, o_p3_line5_out, o_p3_line6_out, o_p3_line7_out, pk_line;
   wire [7:0] o_p0_rx_data, o_p2_rx_data, o_p0_rd_data, o_p2_rd_data, o_p0_pin, o_p0_oe, o_p2_pin, o_p2_oe, pk_data;
   wire [3:0] o_p3_rd_data, o_irq_req;
   wire i_p3_line0_in = l3[0], i_p3_line1_in = l3[1], i_p3_line3_ref_in = l3[3];
   wire i_p3_line2_in = i_p0_hs_en ? pk_line : l3[2];
   wire [7:0] i_p0_pin = (o_p0_oe & o_p0_pin) | (~o_p0_oe & pk_data);
   wire [7:0] p3o = {4'h0, o_p3_line7_out, o_p3_line6_out, o_p3_line5_out, o_p3_line4_out};
   int mismatches = 0, num_checks = 0, cycles = 0;
   three_port_io DUT (.*);
   hs_peer PEER (.clk(i_clk), .en(i_p0_hs_en), .src(src), .hold(hold), .dev_line(o_p3_line5_out),
      .pins(i_p0_pin), .dly(dly), .peer_line(pk_line), .peer_data(pk_data));
   always #10 i_clk = ~i_clk;
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // a hung handshake ends the run here
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         final_report();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   task automatic edge_irq(input int b, input logic v, input logic [7:0] exp);
      int n;
      n = 0;
      l3[b] = v;
      repeat (8) begin
         @(negedge i_clk);
         if (o_irq_req[b] === 1'b1) n++;
      end
      chk(8'(n), exp);
   endtask
   // ====================
   // main sequence
   initial begin
      int n, k;
      cyc(12);
      i_rst_n = 1'b1;
      cyc(2);
      chk(o_p0_oe | o_p2_oe | p3o, 8'h00);
      i_p2_dir_out = 8'ha5;
      i_p2_pin = 8'h96;
      i_p2_wr_data = 8'h3c;
      i_p2_wr = 1'b1;
      i_p2_low_emi = 1'b1;
      cyc(1);
      i_p2_wr = 1'b0;
      cyc(4);
      chk(o_p2_oe, 8'ha5);
      chk(o_p2_pin, 8'h24);
      chk(o_p2_rd_data, 8'h36);
      i_p2_open_drain = 1'b1;
      cyc(2);
      chk(o_p2_oe, 8'h81);
      chk(o_p2_pin, 8'h00);
      chk(8'(o_p2_slow), 8'h01);
      $display("test port2 done");
      i_p0_wr_data = 8'h5a;
      i_p0_wr = 1'b1;
      cyc(1);
      i_p0_wr = 1'b0;
      for (int i = 0; i < 4; i++) begin
         {i_p0_hi_out, i_p0_lo_out} = 2'(i);
         i_p0_low_emi = i[0];
         cyc(2);
         chk(o_p0_oe, {{4{i[1]}}, {4{i[0]}}});
         chk(o_p0_pin, 8'h5a & {{4{i[1]}}, {4{i[0]}}});
         chk(8'(o_p0_slow), 8'(i[0]));
      end
      i_p0_open_drain = 1'b1;
      cyc(2);
      chk(o_p0_oe, 8'ha5);
      chk(o_p0_pin, 8'h00);
      $display("test port0 done");
      i_p3_out_data = 4'ha;
      cyc(2);
      chk(p3o, 8'h0a);
      i_timer1_out_en = 1'b1;
      i_timer1_output = 1'b1;
      cyc(2);
      chk(8'(o_p3_line6_out), 8'h01);
      i_third_port_mode_reg = 8'h02;
      i_power_control_reg = 8'h01;
      i_cmp1_result = 1'b1;
      i_cmp2_result = 1'b1;
      cyc(5);
      chk(8'({o_p3_line7_out, o_p3_line4_out}), 8'h03);
      chk(8'(o_p3_rd_data), 8'h06);
      edge_irq(3, 1'b1, 8'h00);
      edge_irq(3, 1'b0, 8'h00);
      i_cmp1_result = 1'b0;
      i_cmp2_result = 1'b0;
      cyc(5);
      i_third_port_mode_reg = 8'h00;
      edge_irq(3, 1'b1, 8'h00);
      edge_irq(3, 1'b0, 8'h01);
      edge_irq(0, 1'b1, 8'h00);
      edge_irq(0, 1'b0, 8'h01);
      for (int s = 0; s < 3; s++) begin
         i_irq_request_reg = {2'(s), 6'h00};
         for (int b = 1; b < 3; b++) begin
            edge_irq(b, 1'b1, 8'(s != 0));
            edge_irq(b, 1'b0, 8'(s != 1));
         end
      end
      l3 = 4'hb;
      cyc(5);
      chk(8'(o_p3_rd_data), 8'h0b);
      chk(8'(o_timer1_ext_input), 8'h01);
      l3 = 4'h0;
      cyc(4);
      i_p2_dir_out = 8'h00;
      i_p2_hs_en = 1'b1;
      cyc(4);
      chk(8'(o_p3_line6_out), 8'h01);
      i_p2_pin = 8'h5e;
      cyc(2);
      l3[1] = 1'b1;
      cyc(5);
      chk(8'(o_p2_rx_valid), 8'h01);
      chk(o_p2_rx_data, 8'h5e);
      chk(8'(o_p3_line6_out), 8'h00);
      chk(8'(o_p2_tx_busy), 8'h00);
      l3[1] = 1'b0;
      i_p2_rx_ack = 1'b1;
      cyc(1);
      i_p2_rx_ack = 1'b0;
      cyc(6);
      chk(8'(o_p2_rx_valid), 8'h00);
      chk(8'(o_p3_line6_out), 8'h01);
      $display("test port3 done");
      i_p0_open_drain = 1'b0;
      {i_p0_hi_out, i_p0_lo_out} = 2'h3;
      i_p0_hs_en = 1'b1;
      cyc(4);
      n = 0;
      // peer holds ready low, so nothing leaves until the buffer is full
      while (o_p0_tx_ready === 1'b1 && n < 20) begin
         i_p0_wr_data = 8'h40 + 8'(n);
         i_p0_wr = 1'b1;
         n++;
         cyc(1);
      end
      i_p0_wr = 1'b0;
      chk(8'(n), 8'h10);
      chk(8'(o_p3_line5_out), 8'h00);
      hold = 1'b0;
      for (n = 0; n < 3000 && PEER.got.size() < 16; n++) cyc(1);
      chk(8'(PEER.got.size()), 8'h10);
      foreach (PEER.got[i]) chk(PEER.got[i], 8'h40 + 8'(i));
      $display("test send done");
      {i_p0_hi_out, i_p0_lo_out} = 2'h0;
      src = 1'b1;
      for (n = 0; n < 17; n++) PEER.tx.push_back(8'ha0 + 8'(n));
      cyc(400);
      chk(8'(o_p0_rx_valid), 8'h01);
      chk(8'(o_p3_line5_out), 8'h00);
      for (n = 0; n < 17; n++) begin
         for (k = 0; k < 200 && o_p0_rx_valid !== 1'b1; k++) cyc(1);
         chk(o_p0_rx_data, 8'ha0 + 8'(n));
         i_p0_rx_ready = 1'b1;
         cyc(1);
         i_p0_rx_ready = 1'b0;
         cyc(1);
      end
      $display("test receive done");
      final_report();
   end
endmodule
